// ---- rtl/pot_ctrl.sv ----
// Top of the dual log-taper potentiometer control: wipers, taper, storage.
`timescale 1ns/1ps
`default_nettype none
module pot_ctrl #(
  parameter int MS_CYCLES = pot_pkg::MS_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ce_b_in,
  input wire logic addr_strap_0_in,
  input wire logic addr_strap_1_in,
  input wire logic addr_strap_2_in,
  input wire logic zero_cross_0_in,
  input wire logic zero_cross_1_in,
  input wire logic [2:0] nv_cfg_in,
  input wire logic [5:0] nv_wiper0_in,
  input wire logic [5:0] nv_wiper1_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  output logic [5:0] tap0_out,
  output logic [5:0] tap1_out,
  output logic [6:0] atten0_db_out,
  output logic [6:0] atten1_db_out,
  output logic storage_select_out,
  output logic zc_enable_out,
  output logic option_out,
  output logic nv_write_start_out,
  output logic nv_write_busy_out,
  output logic [2:0] nv_cfg_out,
  output logic [5:0] nv_wiper0_out,
  output logic [5:0] nv_wiper1_out
);

  pot_cmd_if cmd_bus ();

  logic [2:0] straps_s1, straps_s2;
  logic [1:0] zc_s1, zc_s2;
  logic [16:0] ms_cnt_q;
  logic ms_tick_q;
  logic loaded_q;
  logic [2:0] cfg_q;
  logic [5:0] target_q [2];
  logic [5:0] tap_q [2];
  logic [1:0] pend_q;
  logic [5:0] zc_ms_q [2];
  logic nv_dirty_q, nv_arm_q;
  logic [3:0] nv_ms_q;
  logic wr_wiper, wr_cfg;
  logic [1:0] cmd_code;
  logic nv_go;

  // Fast-mode SCL at 400 kHz is oversampled by the core clock.
  pot_i2c_slave u_slave (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ce_b_in(ce_b_in),
    .addr_strap_in(straps_s2),
    .sda_oe_b_out(sda_oe_b_out),
    .cmd(cmd_bus.slave)
  );

  // Attenuation in dB for a tap code under the selected option.
  function automatic logic [6:0] atten_db(input logic opt,
                                          input logic [5:0] code);
    logic [6:0] c;
    c = {1'b0, code};
    if (!opt) begin
      atten_db = (code == pot_pkg::OPT1_MUTE) ? pot_pkg::MUTE_DB : c;
    end else if (code <= pot_pkg::OPT2_BAND1_END) begin
      atten_db = c;
    end else if (code <= pot_pkg::OPT2_BAND2_END) begin
      atten_db = 7'((c - {1'b0, pot_pkg::OPT2_BAND1_END}) * 7'h02 +
                    pot_pkg::OPT2_BAND2_BASE_DB);
    end else if (code < pot_pkg::OPT2_MUTE) begin
      atten_db = 7'((c - {1'b0, pot_pkg::OPT2_BAND2_END}) * 7'h03 +
                    pot_pkg::OPT2_BAND3_BASE_DB);
    end else begin
      atten_db = pot_pkg::MUTE_DB;
    end
  endfunction

  // Mute code for an option.
  function automatic logic [5:0] mute_code(input logic opt);
    mute_code = opt ? pot_pkg::OPT2_MUTE : pot_pkg::OPT1_MUTE;
  endfunction

  // Straps and comparator levels come from pins and are synchronised.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      straps_s1 <= 3'h0;
      straps_s2 <= 3'h0;
      zc_s1 <= 2'h0;
      zc_s2 <= 2'h0;
    end else begin
      straps_s1 <= {addr_strap_2_in, addr_strap_1_in, addr_strap_0_in};
      straps_s2 <= straps_s1;
      zc_s1 <= {zero_cross_1_in, zero_cross_0_in};
      zc_s2 <= zc_s1;
    end
  end

  // Millisecond enable; a timeout may run up to one tick short.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ms_cnt_q <= 17'h0_0000;
      ms_tick_q <= 1'b0;
    end else if (ms_cnt_q == 17'(MS_CYCLES - 1)) begin
      ms_cnt_q <= 17'h0_0000;
      ms_tick_q <= 1'b1;
    end else begin
      ms_cnt_q <= ms_cnt_q + 17'h0_0001;
      ms_tick_q <= 1'b0;
    end
  end

  // Command decode; code 11 falls through and does nothing.
  assign cmd_code = cmd_bus.cmd_byte[7:6];
  assign wr_wiper = cmd_bus.cmd_valid && !cmd_code[1];
  assign wr_cfg = cmd_bus.cmd_valid &&
                  (cmd_code == pot_pkg::CMD_CONFIG);

  // Configuration: taken from storage once after reset, then by command.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_q <= pot_pkg::CFG_RESET;
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      cfg_q <= nv_cfg_in;
      loaded_q <= 1'b1;
    end else if (wr_cfg) begin
      cfg_q <= cmd_bus.cmd_byte[2:0];
    end
  end

  // Per channel: capture target, wait for a crossing or time out. Being
  // level-driven, a channel already at zero moves on the next cycle.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 2; i++) begin
        target_q[i] <= pot_pkg::OPT2_MUTE;
        tap_q[i] <= pot_pkg::OPT2_MUTE;
        zc_ms_q[i] <= 6'h00;
      end
      pend_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!loaded_q) begin
          // Volatile wipers wake at mute; stored ones are restored.
          tap_q[i] <= nv_cfg_in[pot_pkg::CFG_VOLATILE_BIT] ?
                      mute_code(nv_cfg_in[pot_pkg::CFG_OPTION_BIT]) :
                      (i == 0 ? nv_wiper0_in : nv_wiper1_in);
          target_q[i] <= nv_cfg_in[pot_pkg::CFG_VOLATILE_BIT] ?
                         mute_code(nv_cfg_in[pot_pkg::CFG_OPTION_BIT]) :
                         (i == 0 ? nv_wiper0_in : nv_wiper1_in);
        end else if (wr_wiper && cmd_code[0] == i[0]) begin
          target_q[i] <= cmd_bus.cmd_byte[5:0];
          if (cfg_q[pot_pkg::CFG_ZC_BIT]) begin
            pend_q[i] <= 1'b1;
            zc_ms_q[i] <= 6'h00;
          end else begin
            tap_q[i] <= cmd_bus.cmd_byte[5:0];
            pend_q[i] <= 1'b0;
          end
        end else if (pend_q[i]) begin
          if (zc_s2[i] || zc_ms_q[i] == 6'(pot_pkg::ZC_TIMEOUT_MS)) begin
            tap_q[i] <= target_q[i];
            pend_q[i] <= 1'b0;
          end else if (ms_tick_q) begin
            zc_ms_q[i] <= zc_ms_q[i] + 6'h01;
          end
        end
      end
    end
  end

  // A config write, or a wiper write while nonvolatile, needs storing.
  // The new command wins over the clear from a STOP just seen.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nv_dirty_q <= 1'b0;
      nv_arm_q <= 1'b0;
    end else begin
      if (wr_cfg ||
          (wr_wiper && !cfg_q[pot_pkg::CFG_VOLATILE_BIT])) begin
        nv_dirty_q <= 1'b1;
      end else if (cmd_bus.stop_seen) begin
        nv_dirty_q <= 1'b0;
      end
      if (cmd_bus.stop_seen && nv_dirty_q) begin
        nv_arm_q <= 1'b1;
      end else if (nv_go) begin
        nv_arm_q <= 1'b0;
      end
    end
  end

  // With zero-cross on, the write waits until no channel is pending.
  assign nv_go = nv_arm_q && !nv_write_busy_out &&
                 !(cfg_q[pot_pkg::CFG_ZC_BIT] && |pend_q);

  // Nonvolatile write: one start pulse, with busy raised on the same edge and held for the write time.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nv_write_start_out <= 1'b0;
      nv_write_busy_out <= 1'b0;
      nv_ms_q <= 4'h0;
      nv_cfg_out <= pot_pkg::CFG_RESET;
      nv_wiper0_out <= pot_pkg::OPT2_MUTE;
      nv_wiper1_out <= pot_pkg::OPT2_MUTE;
    end else begin
      nv_write_start_out <= nv_go;
      if (nv_go) begin
        nv_write_busy_out <= 1'b1;
        nv_ms_q <= 4'h0;
        nv_cfg_out <= cfg_q;
        nv_wiper0_out <= target_q[0];
        nv_wiper1_out <= target_q[1];
      end else if (nv_write_busy_out && ms_tick_q) begin
        if (nv_ms_q == 4'(pot_pkg::NV_WRITE_TIME_MS - 1)) begin
          nv_write_busy_out <= 1'b0;
        end
        nv_ms_q <= nv_ms_q + 4'h1;
      end
    end
  end

  // Registered view of taps, taper and configuration; the one option
  // bit governs both channels together.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tap0_out <= pot_pkg::OPT2_MUTE;
      tap1_out <= pot_pkg::OPT2_MUTE;
      atten0_db_out <= pot_pkg::MUTE_DB;
      atten1_db_out <= pot_pkg::MUTE_DB;
      storage_select_out <= 1'b1;
      zc_enable_out <= 1'b1;
      option_out <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      tap0_out <= tap_q[0];
      tap1_out <= tap_q[1];
      atten0_db_out <= atten_db(cfg_q[pot_pkg::CFG_OPTION_BIT], tap_q[0]);
      atten1_db_out <= atten_db(cfg_q[pot_pkg::CFG_OPTION_BIT], tap_q[1]);
      storage_select_out <= cfg_q[pot_pkg::CFG_VOLATILE_BIT];
      zc_enable_out <= cfg_q[pot_pkg::CFG_ZC_BIT];
      option_out <= cfg_q[pot_pkg::CFG_OPTION_BIT];
      sda_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- shared/pot_pkg.sv ----
// Shared constants and types for the dual log-taper potentiometer control.
package pot_pkg;

  // Core clock and derived millisecond tick.
  localparam int CLK_HZ = 125_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

  // Longest zero-crossing wait and nonvolatile write time, in ms.
  localparam int ZC_TIMEOUT_MS = 50;
  localparam int NV_WRITE_TIME_MS = 10;

  // Fastest SCL the slave is built for (fast mode), in Hz.
  localparam int SCL_MAX_HZ = 400_000;

  // Slave address: fixed upper nibble, then three straps and R/W.
  localparam logic [3:0] ADDR_PREFIX = 4'h5;

  // Command byte top-two-bit codes.
  localparam logic [1:0] CMD_WIPER0 = 2'h0;
  localparam logic [1:0] CMD_WIPER1 = 2'h1;
  localparam logic [1:0] CMD_CONFIG = 2'h2;

  // Configuration field positions and reset value.
  localparam int CFG_VOLATILE_BIT = 2;
  localparam int CFG_ZC_BIT = 1;
  localparam int CFG_OPTION_BIT = 0;
  localparam logic [2:0] CFG_RESET = 3'h7;

  // Tap codes and attenuation figures.
  localparam logic [5:0] OPT1_MUTE = 6'h3f;
  localparam logic [5:0] OPT2_MUTE = 6'h21;
  localparam logic [5:0] OPT2_BAND1_END = 6'h0c;
  localparam logic [5:0] OPT2_BAND2_END = 6'h18;
  localparam logic [6:0] OPT2_BAND2_BASE_DB = 7'h0c;
  localparam logic [6:0] OPT2_BAND3_BASE_DB = 7'h24;
  localparam logic [6:0] MUTE_DB = 7'h50;

  // Serial slave states.
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ADDR = 5'h02,
    S_DATA = 5'h04,
    S_ACK = 5'h08,
    S_SKIP = 5'h10
  } slave_state_type;

endpackage

// ---- shared/pot_cmd_if.sv ----
// Command hand-off between the serial slave and the potentiometer control.
`timescale 1ns/1ps
`default_nettype none
interface pot_cmd_if;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic stop_seen;
  modport slave(output cmd_valid, output cmd_byte, output stop_seen);
  modport ctrl(input cmd_valid, input cmd_byte, input stop_seen);
endinterface
`default_nettype wire

// ---- rtl/pot_i2c_slave.sv ----
// Write-only serial slave that delivers command bytes to the control.
`timescale 1ns/1ps
`default_nettype none
module pot_i2c_slave (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ce_b_in,
  input wire logic [2:0] addr_strap_in,
  output logic sda_oe_b_out,
  pot_cmd_if.slave cmd
);

  logic scl_s1, scl_s2, scl_prev;
  logic sda_s1, sda_s2, sda_prev;
  logic ce_s1, ce_s2;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  pot_pkg::slave_state_type state_q;
  logic active, start_det, stop_det, scl_rise, scl_fall, addr_hit;

  // Two flops on every pin; only the second stage and the SCL and SDA edge flops feed any logic.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {scl_s1, scl_s2, scl_prev} <= 3'h7;
      {sda_s1, sda_s2, sda_prev} <= 3'h7;
      {ce_s1, ce_s2} <= 2'h3;
    end else begin
      {scl_s2, scl_s1} <= {scl_s1, scl_in};
      {sda_s2, sda_s1} <= {sda_s1, sda_in};
      {ce_s2, ce_s1} <= {ce_s1, ce_b_in};
      scl_prev <= scl_s2;
      sda_prev <= sda_s2;
    end
  end

  // Bus conditions are seen only while the enable pin is low.
  assign active = !ce_s2;
  assign start_det = active && scl_s2 && scl_prev && sda_prev && !sda_s2;
  assign stop_det = active && scl_s2 && scl_prev && !sda_prev && sda_s2;
  assign scl_rise = active && scl_s2 && !scl_prev;
  assign scl_fall = active && !scl_s2 && scl_prev;
  // Reads are not answered, so only a write address is acknowledged.
  assign addr_hit = (shift_q[7:4] == pot_pkg::ADDR_PREFIX) &&
                    (shift_q[3:1] == addr_strap_in) && !shift_q[0];

  // Byte engine: sample on SCL rise, move SDA only on SCL fall, on START or STOP, or when disabled.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= pot_pkg::S_IDLE;
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      sda_oe_b_out <= 1'b1;
    end else if (!active) begin
      state_q <= pot_pkg::S_IDLE;
      bit_cnt_q <= 4'h0;
      sda_oe_b_out <= 1'b1;
    end else if (start_det) begin
      state_q <= pot_pkg::S_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_b_out <= 1'b1;
    end else if (stop_det) begin
      state_q <= pot_pkg::S_IDLE;
      sda_oe_b_out <= 1'b1;
    end else begin
      case (state_q)
        pot_pkg::S_ADDR, pot_pkg::S_DATA: begin
          if (scl_rise && bit_cnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s2};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            if (state_q == pot_pkg::S_DATA || addr_hit) begin
              sda_oe_b_out <= 1'b0;
              state_q <= pot_pkg::S_ACK;
            end else begin
              state_q <= pot_pkg::S_SKIP;
            end
          end
        end
        pot_pkg::S_ACK: begin
          if (scl_fall) begin
            sda_oe_b_out <= 1'b1;
            bit_cnt_q <= 4'h0;
            state_q <= pot_pkg::S_DATA;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // A command byte is handed over as its acknowledge is driven.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd.cmd_valid <= 1'b0;
      cmd.cmd_byte <= 8'h00;
      cmd.stop_seen <= 1'b0;
    end else begin
      cmd.cmd_valid <= (state_q == pot_pkg::S_DATA) && scl_fall &&
                       (bit_cnt_q == 4'h8) && !start_det && !stop_det;
      cmd.cmd_byte <= shift_q;
      cmd.stop_seen <= stop_det;
    end
  end

endmodule
`default_nettype wire

// ---- bench/pot_ctrl_asserts.sv ----
// Concurrent checks on the ports of the potentiometer control.
`timescale 1ns/1ps
`default_nettype none
module pot_ctrl_asserts (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic ce_b_in,
  input wire logic sda_oe_b_out,
  input wire logic [5:0] tap0_out,
  input wire logic [5:0] tap1_out,
  input wire logic [6:0] atten0_db_out,
  input wire logic [6:0] atten1_db_out,
  input wire logic option_out,
  input wire logic nv_write_start_out,
  input wire logic nv_write_busy_out
);
  // Attenuation of a tap in the banded option; codes past 32 read as mute.
  function automatic logic [6:0] opt2_db(input logic [5:0] t);
    if (t <= 6'h0c) return {1'b0, t};
    if (t <= 6'h18) return {t, 1'b0} - 7'h0c;
    if (t <= 6'h20) return {t, 1'b0} + {1'b0, t} - 7'h24;
    return 7'h50;
  endfunction

  // Option must settle two cycles, though the dB figure is registered in the same cycle as it.
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  AST_OPT1_STEP: assert property (!option_out && !$past(option_out) &&
    !$past(option_out, 2) && tap0_out != 6'h3f
    |-> atten0_db_out == {1'b0, tap0_out}) else $error("opt1 step dB");
  AST_OPT1_MUTE: assert property (!option_out && !$past(option_out) &&
    !$past(option_out, 2) && tap1_out == 6'h3f
    |-> atten1_db_out == 7'h50) else $error("opt1 mute dB");
  AST_OPT2_MAP: assert property (option_out && $past(option_out) &&
    $past(option_out, 2) |-> atten0_db_out == opt2_db(tap0_out) &&
    atten1_db_out == opt2_db(tap1_out)) else $error("opt2 band dB");
  AST_CE_IGNORE: assert property (ce_b_in [*6] |-> sda_oe_b_out)
    else $error("ack while disabled");
  AST_ACK_SCL_LOW: assert property ($fell(sda_oe_b_out) |-> !scl_in)
    else $error("ack driven with clock high");
  AST_ACK_HOLD: assert property (!sda_oe_b_out && scl_in |=>
    !sda_oe_b_out) else $error("ack dropped with clock high");
  AST_ACK_SPAN: assert property ($fell(sda_oe_b_out) |->
    ##[60:400] sda_oe_b_out) else $error("ack length");
  AST_NV_PULSE: assert property (nv_write_start_out |=>
    !nv_write_start_out && nv_write_busy_out) else $error("nv start");
  AST_BUSY_CAUSE: assert property ($rose(nv_write_busy_out) |->
    nv_write_start_out) else $error("busy without start");
endmodule
bind pot_ctrl pot_ctrl_asserts i_chk (.clk_in, .rst_b_in, .scl_in,
  .ce_b_in, .sda_oe_b_out, .tap0_out, .tap1_out, .atten0_db_out,
  .atten1_db_out, .option_out, .nv_write_start_out, .nv_write_busy_out);
`default_nettype wire

// ---- bench/i2c_master_model.sv ----
// Bus master model driving SCL and an open-drain SDA.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
  parameter int Q = 79
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // A bit lasts 4*Q cycles, just under the fast-mode rate.
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wq(input int n);
    repeat (n * Q) @(negedge clk_in);
  endtask
  // Data moves only while SCL is low, so no false START or STOP.
  task automatic bit_x(input logic b, output logic s);
    wq(1);
    sda_out = b;
    wq(1);
    scl_out = 1'b1;
    wq(1);
    s = sda_in;
    wq(1);
    scl_out = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(v[i], s);
    end
    bit_x(1'b1, s);
    ack = !s;
  endtask
  // Address first, then up to two command bytes, then STOP.
  task automatic write(input logic [7:0] a, input logic [7:0] c0,
    input logic [7:0] c1, input int n, output logic ack);
    logic k;
    wq(1);
    sda_out = 1'b0;
    wq(1);
    scl_out = 1'b0;
    send_byte(a, ack);
    if (ack && n > 0) send_byte(c0, k);
    if (ack && n > 1) send_byte(c1, k);
    wq(1);
    sda_out = 1'b0;
    wq(1);
    scl_out = 1'b1;
    wq(1);
    sda_out = 1'b1;
    wq(2);
  endtask
endmodule
`default_nettype wire

// ---- bench/test_pot_ctrl.sv ----
// Self-checking bench for the potentiometer control.
`timescale 1ns/1ps
`default_nettype none
module test_pot_ctrl;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce_b_in = 1'b0;
  logic [2:0] strap = 3'h5;
  logic zc0 = 1'b0;
  logic zc1 = 1'b0;
  logic scl, m_sda, sda_o, oe_b, st, busy, sel, zce, opt, ack;
  logic [5:0] t0, t1, w0, w1;
  logic [2:0] nvc;
  logic [6:0] a0, a1;
  int failures = 0;
  int total_checks = 0;
  int starts = 0;
  // Pull-up wire: released by both parties it reads high.
  wire logic sda = m_sda & (oe_b | sda_o);

  pot_ctrl #(.MS_CYCLES(20)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .scl_in(scl), .sda_in(sda), .ce_b_in(ce_b_in),
    .addr_strap_0_in(strap[0]), .addr_strap_1_in(strap[1]),
    .addr_strap_2_in(strap[2]), .zero_cross_0_in(zc0),
    .zero_cross_1_in(zc1), .nv_cfg_in(3'h0), .nv_wiper0_in(6'h05),
    .nv_wiper1_in(6'h3f), .sda_out(sda_o), .sda_oe_b_out(oe_b),
    .tap0_out(t0), .tap1_out(t1), .atten0_db_out(a0),
    .atten1_db_out(a1), .storage_select_out(sel), .zc_enable_out(zce),
    .option_out(opt), .nv_write_start_out(st),
    .nv_write_busy_out(busy), .nv_cfg_out(nvc), .nv_wiper0_out(w0),
    .nv_wiper1_out(w1));
  i2c_master_model i_master (.clk_in(clk_in), .sda_in(sda),
    .scl_out(scl), .sda_out(m_sda));

  always #4 clk_in = ~clk_in;
  // Count write pulses so a missed or doubled store shows.
  always @(posedge clk_in) if (st === 1'b1) starts++;

  function automatic logic [7:0] adr(input logic [2:0] s);
    return {pot_pkg::ADDR_PREFIX, s, 1'b0};
  endfunction
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk_in);
    chk("busy", 8'h00, {7'h0, busy});
  endtask
  task automatic t_reset;
    chk("tap0", 8'h05, {2'h0, t0});
    chk("atten0", 8'h05, {1'h0, a0});
    chk("atten1", 8'h50, {1'h0, a1});
    chk("cfg", 8'h00, {5'h0, sel, zce, opt});
  endtask
  task automatic t_wiper;
    starts = 0;
    i_master.write(adr(strap), {pot_pkg::CMD_WIPER0, 6'h0a},
      {pot_pkg::CMD_WIPER1, 6'h20}, 2, ack);
    chk("ack", 8'h01, {7'h0, ack});
    chk("tap0", 8'h0a, {2'h0, t0});
    chk("atten1", 8'h20, {1'h0, a1});
    chk("starts", 8'h01, 8'(starts));
    chk("nvw0", 8'h0a, {2'h0, w0});
    chk("nvw1", 8'h20, {2'h0, w1});
    wait_idle();
  endtask
  // Wrong strap, read request, then bus disabled: none may answer.
  task automatic t_refuse;
    for (int i = 0; i < 3; i++) begin
      ce_b_in = (i == 2);
      i_master.write(adr(strap ^ ((i == 0) ? 3'h1 : 3'h0)) |
        ((i == 1) ? 8'h01 : 8'h00), {pot_pkg::CMD_WIPER0, 6'h01},
        8'h00, 1, ack);
      chk("ack", 8'h00, {7'h0, ack});
    end
    ce_b_in = 1'b0;
    chk("tap0", 8'h0a, {2'h0, t0});
  endtask
  task automatic t_zc;
    starts = 0;
    i_master.write(adr(strap), {pot_pkg::CMD_CONFIG, 6'h03},
      {pot_pkg::CMD_WIPER1, 6'h0d}, 2, ack);
    chk("cfg", 8'h03, {5'h0, sel, zce, opt});
    chk("atten1", 8'h3c, {1'h0, a1});
    chk("starts", 8'h00, 8'(starts));
    zc1 = 1'b1;
    repeat (10) @(negedge clk_in);
    chk("tap1", 8'h0d, {2'h0, t1});
    chk("atten1", 8'h0e, {1'h0, a1});
    chk("starts", 8'h01, 8'(starts));
    zc1 = 1'b0;
    wait_idle();
  endtask
  // The wait runs from the wiper byte's acknowledge, about 700 cycles
  // before the write returns, so the early look must stay well short.
  task automatic t_timeout;
    i_master.write(adr(strap), 8'hc0, {pot_pkg::CMD_WIPER0, 6'h19}, 2,
      ack);
    chk("tap1", 8'h0d, {2'h0, t1});
    repeat (200) @(negedge clk_in);
    chk("tap0", 8'h0a, {2'h0, t0});
    for (int i = 0; i < 400 && t0 !== 6'h19; i++) @(negedge clk_in);
    chk("tap0", 8'h19, {2'h0, t0});
    chk("atten0", 8'h27, {1'h0, a0});
    wait_idle();
  endtask
  // Volatile wipers move at once but a wiper write alone is not stored.
  task automatic t_volatile;
    starts = 0;
    i_master.write(adr(strap), {pot_pkg::CMD_CONFIG, 6'h04},
      {pot_pkg::CMD_WIPER0, 6'h3e}, 2, ack);
    chk("atten0", 8'h3e, {1'h0, a0});
    chk("starts", 8'h01, 8'(starts));
    chk("nvcfg", 8'h04, {5'h0, nvc});
    wait_idle();
    i_master.write(adr(strap), {pot_pkg::CMD_WIPER1, 6'h3f}, 8'h00, 1,
      ack);
    chk("cfg", 8'h04, {5'h0, sel, zce, opt});
    chk("atten1", 8'h50, {1'h0, a1});
    repeat (10) @(negedge clk_in);
    chk("starts", 8'h01, 8'(starts));
  endtask
  task automatic end_of_test;
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (10) @(negedge clk_in);
    t_reset();
    t_wiper();
    t_refuse();
    t_zc();
    t_timeout();
    t_volatile();
    end_of_test();
  end
  // The sequence needs about 55000 cycles; this cuts a hang.
  initial begin
    repeat (80000) @(posedge clk_in);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
